// file: shared/trig_pkg.sv
// constants and types for the analog trigger detector
package trig_pkg;
  localparam int NUM_CH = 4;
  localparam int SAMPLE_W = 16;
  localparam int CH_W = 2;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] LEVEL_OFF = 8'h04;
  localparam logic [7:0] HYST_OFF = 8'h08;
  localparam logic [7:0] TOP_OFF = 8'h0C;
  localparam logic [7:0] BOTTOM_OFF = 8'h10;
  localparam logic [7:0] STATUS_OFF = 8'h14;
  localparam logic [7:0] INTMASK_OFF = 8'h18;
  localparam logic [7:0] INTSTAT_OFF = 8'h1C;
  // control fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_MODE_W = 3;
  localparam int CTRL_CH_LSB = 4;
  localparam int CTRL_AI_BIT = 6;
  localparam int CTRL_AO_BIT = 7;
  localparam int CTRL_CTR_BIT = 8;
  // writable control bits
  localparam logic [31:0] CTRL_WMASK = 32'h0000_01FF;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [SAMPLE_W-1:0] LEVEL_RST = 16'h0000;
  localparam logic [SAMPLE_W-1:0] HYST_RST = 16'h0000;
  localparam logic [SAMPLE_W-1:0] TOP_RST = 16'h0000;
  localparam logic [SAMPLE_W-1:0] BOTTOM_RST = 16'h0000;
  localparam logic [1:0] INTMASK_RST = 2'h0;
  // interrupt status bits
  localparam int IRQ_RISE_BIT = 0;
  localparam int IRQ_FALL_BIT = 1;

  typedef enum logic [2:0] {
    MODE_BELOW = 3'b000,
    MODE_ABOVE = 3'b001,
    MODE_HYST_RISE = 3'b010,
    MODE_HYST_FALL = 3'b011,
    MODE_WIN_ENTER = 3'b100,
    MODE_WIN_LEAVE = 3'b101
  } mode_type;
endpackage : trig_pkg

// file: rtl/analog_trigger_detect.sv
// analog trigger detector with apb register file
`timescale 1ns/1ps

// Notes on behaviour
// RL1 - input taken from the software-selected amplified analog channel
// RL2 - below-level mode: event while input is less than level
// RL3 - above-level mode: event while input is greater than level
// RL4 - rising hysteresis: upper is level, lower is level minus hysteresis
// RL5 - rising hysteresis asserts after below lower, then above upper
// RL6 - rising hysteresis event holds until input falls below lower
// RL7 - falling hysteresis: lower is level, upper is level plus hysteresis
// RL8 - falling hysteresis asserts after above upper, then below lower
// RL9 - falling hysteresis event holds until input rises above upper
// RL10 - window mode triggers on entering or leaving band, software selects
// RL11 - software writes top and bottom before using window mode
// RL12 - event output routable to acquisition, generation or counters
// RL13 - configuring level or window limits updates trigger dac outputs
// RL14 - window event stays active while input inside (enter) or outside
module analog_trigger_detect
  import trig_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // amplified analog samples, one per channel, unsigned
  input wire logic [NUM_CH*SAMPLE_W-1:0] chanSamples,
  // trigger dac references
  output logic [SAMPLE_W-1:0] dacUpper,
  output logic [SAMPLE_W-1:0] dacLower,
  // comparison event and its routes
  output logic compEvent,
  output logic aiTrigger,
  output logic aoTrigger,
  output logic ctrTrigger,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [SAMPLE_W-1:0] level_r;
  logic [SAMPLE_W-1:0] hyst_r;
  logic [SAMPLE_W-1:0] top_r;
  logic [SAMPLE_W-1:0] bottom_r;
  logic [1:0] intMask_r;
  logic [1:0] intStat_r;
  logic [1:0] intStat_nxt;
  logic armed_r;
  logic event_r;
  logic event_nxt;
  logic armed_nxt;
  logic [SAMPLE_W-1:0] sample_r;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire accessPhase = psel & penable;
  wire wrEn = accessPhase & pwrite;
  wire rdEn = accessPhase & ~pwrite;
  wire selCtrl = (paddr == CTRL_OFF);
  wire selLevel = (paddr == LEVEL_OFF);
  wire selHyst = (paddr == HYST_OFF);
  wire selTop = (paddr == TOP_OFF);
  wire selBottom = (paddr == BOTTOM_OFF);
  wire selStatus = (paddr == STATUS_OFF);
  wire selMask = (paddr == INTMASK_OFF);
  wire selIntStat = (paddr == INTSTAT_OFF);
  wire mapped = selCtrl | selLevel | selHyst | selTop | selBottom
    | selStatus | selMask | selIntStat;
  // per-register write strobes, taken at the access edge
  wire wrCtrl = wrEn & selCtrl;
  wire wrLevel = wrEn & selLevel;
  wire wrHyst = wrEn & selHyst;
  wire wrTop = wrEn & selTop;
  wire wrBottom = wrEn & selBottom;
  wire wrMask = wrEn & selMask;
  wire setupPhase = psel & ~penable;

  wire trigEnable = ctrl_r[CTRL_ENABLE_BIT];
  wire [CTRL_MODE_W-1:0] modeBits = ctrl_r[CTRL_MODE_LSB +: CTRL_MODE_W];
  wire [CH_W-1:0] chanSel = ctrl_r[CTRL_CH_LSB +: CH_W];
  mode_type mode;
  assign mode = mode_type'(modeBits);

  // ----------------------------------------------------------------
  // thresholds
  // ----------------------------------------------------------------
  wire [SAMPLE_W:0] lowDiff = {1'b0, level_r} - {1'b0, hyst_r};
  wire [SAMPLE_W:0] highSum = {1'b0, level_r} + {1'b0, hyst_r};
  // saturate so an over-range hysteresis pins at the rail
  wire [SAMPLE_W-1:0] riseLow = lowDiff[SAMPLE_W] ? '0
    : lowDiff[SAMPLE_W-1:0]; // RL4
  wire [SAMPLE_W-1:0] fallHigh = highSum[SAMPLE_W] ? '1
    : highSum[SAMPLE_W-1:0]; // RL7
  wire isFall = (mode == MODE_HYST_FALL);
  wire isWin = (mode == MODE_WIN_ENTER) || (mode == MODE_WIN_LEAVE);
  wire [SAMPLE_W-1:0] upperRef = isWin ? top_r
    : (isFall ? fallHigh : level_r);
  wire [SAMPLE_W-1:0] lowerRef = isWin ? bottom_r
    : (isFall ? level_r : riseLow);

  // ----------------------------------------------------------------
  // comparison
  // ----------------------------------------------------------------
  wire [SAMPLE_W-1:0] chanPick =
    chanSamples[chanSel*SAMPLE_W +: SAMPLE_W]; // RL1
  // strict compares, window bounds inclusive
  wire belowLevel = sample_r < level_r;
  wire aboveLevel = sample_r > level_r;
  wire belowLower = sample_r < lowerRef;
  wire aboveUpper = sample_r > upperRef;
  wire inWindow = (sample_r >= bottom_r) && (sample_r <= top_r);

  always_comb begin
    event_nxt = event_r;
    armed_nxt = armed_r;
    case (mode)
      MODE_BELOW: begin
        event_nxt = belowLevel; // RL2
        armed_nxt = 1'b0;
      end
      MODE_ABOVE: begin
        event_nxt = aboveLevel; // RL3
        armed_nxt = 1'b0;
      end
      MODE_HYST_RISE: begin
        if (event_r) begin
          if (belowLower) begin
            event_nxt = 1'b0; // RL6
            armed_nxt = 1'b1;
          end
        end else if (belowLower) begin
          armed_nxt = 1'b1;
        end else if (armed_r && aboveUpper) begin
          event_nxt = 1'b1; // RL5
          armed_nxt = 1'b0;
        end
      end
      MODE_HYST_FALL: begin
        if (event_r) begin
          if (aboveUpper) begin
            event_nxt = 1'b0; // RL9
            armed_nxt = 1'b1;
          end
        end else if (aboveUpper) begin
          armed_nxt = 1'b1;
        end else if (armed_r && belowLower) begin
          event_nxt = 1'b1; // RL8
          armed_nxt = 1'b0;
        end
      end
      MODE_WIN_ENTER: begin
        event_nxt = inWindow; // RL10 RL14
        armed_nxt = 1'b0;
      end
      MODE_WIN_LEAVE: begin
        event_nxt = ~inWindow; // RL10 RL14
        armed_nxt = 1'b0;
      end
      default: begin
        event_nxt = 1'b0;
        armed_nxt = 1'b0;
      end
    endcase
    // a control write restarts detection so no arm carries across modes
    if (!trigEnable || wrCtrl) begin
      event_nxt = 1'b0;
      armed_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  wire riseEv = event_nxt & ~event_r;
  wire fallEv = ~event_nxt & event_r;
  wire intRd = rdEn & selIntStat;
  // clear only bits the read returned; a new event wins over the clear
  wire [1:0] intClr = intRd ? prdata[1:0] : 2'h0;
  assign intStat_nxt = (intStat_r & ~intClr) | {fallEv, riseEv};

  wire [31:0] rdMux =
    selCtrl ? ctrl_r :
    selLevel ? {16'h0000, level_r} :
    selHyst ? {16'h0000, hyst_r} :
    selTop ? {16'h0000, top_r} :
    selBottom ? {16'h0000, bottom_r} :
    selStatus ? {30'h0000000, armed_r, event_r} :
    selMask ? {30'h0000000, intMask_r} :
    selIntStat ? {30'h0000000, intStat_r} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // event routing
  // ----------------------------------------------------------------
  // each consumer gets its own gated copy of the event
  wire routeAi = event_nxt & ctrl_r[CTRL_AI_BIT]; // RL12
  wire routeAo = event_nxt & ctrl_r[CTRL_AO_BIT]; // RL12
  wire routeCtr = event_nxt & ctrl_r[CTRL_CTR_BIT]; // RL12

  // ----------------------------------------------------------------
  // clocked state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_r <= CTRL_RST;
    end else if (wrCtrl) begin
      ctrl_r <= pwdata & CTRL_WMASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      level_r <= LEVEL_RST;
    end else if (wrLevel) begin
      level_r <= pwdata[SAMPLE_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hyst_r <= HYST_RST;
    end else if (wrHyst) begin
      hyst_r <= pwdata[SAMPLE_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      top_r <= TOP_RST;
    end else if (wrTop) begin
      top_r <= pwdata[SAMPLE_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bottom_r <= BOTTOM_RST;
    end else if (wrBottom) begin
      bottom_r <= pwdata[SAMPLE_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      intMask_r <= INTMASK_RST;
    end else if (wrMask) begin
      intMask_r <= pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // detector state
  // ----------------------------------------------------------------
  // one sample stage ahead of the detector
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sample_r <= '0;
    end else begin
      sample_r <= chanPick;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      event_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      event_r <= event_nxt;
      armed_r <= armed_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      intStat_r <= 2'h0;
    end else begin
      intStat_r <= intStat_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // bus answer, launched at the setup edge
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setupPhase;
      pslverr <= setupPhase & ~mapped;
      prdata <= (setupPhase & ~pwrite) ? rdMux : 32'h0000_0000;
    end
  end

  // references follow the mode and levels on the next clock
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dacUpper <= '0;
      dacLower <= '0;
    end else begin
      dacUpper <= upperRef; // RL13
      dacLower <= lowerRef; // RL13
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      compEvent <= 1'b0;
      aiTrigger <= 1'b0;
      aoTrigger <= 1'b0;
      ctrTrigger <= 1'b0;
    end else begin
      compEvent <= event_nxt; // RL12
      aiTrigger <= routeAi; // RL12
      aoTrigger <= routeAo; // RL12
      ctrTrigger <= routeCtr; // RL12
    end
  end

  // irq follows the updated status
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStat_nxt & intMask_r);
    end
  end

endmodule : analog_trigger_detect

// file: verif/afe_model.sv
// front end model feeding amplified samples to the detector
`timescale 1ns/1ps
module afe_model
  import trig_pkg::*;
(
  // chosen channel and its level
  input logic [CH_W-1:0] chan,
  input logic [SAMPLE_W-1:0] level,
  // amplified samples
  output logic [NUM_CH*SAMPLE_W-1:0] chanSamples
);
  // other lanes carry the inverse so a wrong pick shows
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      chanSamples[i*SAMPLE_W +: SAMPLE_W] = i == chan ? level : ~level;
    end
  end
endmodule : afe_model

// file: verif/analog_trigger_detect_chk.sv
// port checker of the analog trigger detector
`timescale 1ns/1ps
module analog_trigger_detect_chk
  import trig_pkg::*;
(
  // clock and reset
  input logic clk_sys,
  input logic reset,
  // apb
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic pready,
  input logic pslverr,
  // detector
  input logic [NUM_CH*SAMPLE_W-1:0] chanSamples,
  input logic [SAMPLE_W-1:0] dacUpper,
  input logic [SAMPLE_W-1:0] dacLower,
  input logic compEvent,
  input logic aiTrigger,
  input logic aoTrigger,
  input logic ctrTrigger
);
  logic [8:0] ctl_r;
  logic [15:0] lvl_r, hys_r;
  logic [15:0] top_r, bot_r;
  logic [1:0] quiet_r;
  wire wrDone = psel && penable && pready && pwrite && !pslverr;
  wire [2:0] mode = ctl_r[3:1];
  wire settled = quiet_r == 2'h3 && ctl_r[0];
  wire [15:0] sel = chanSamples[ctl_r[5:4]*SAMPLE_W +: SAMPLE_W];
  wire [16:0] upSum = {1'b0, lvl_r} + {1'b0, hys_r};
  // shadow of the setup, quiet counts cycles since a write
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctl_r <= 9'h000;
      lvl_r <= 16'h0000;
      hys_r <= 16'h0000;
      top_r <= 16'h0000;
      bot_r <= 16'h0000;
      quiet_r <= 2'h0;
    end else begin
      if (wrDone && paddr == CTRL_OFF) ctl_r <= pwdata[8:0];
      if (wrDone && paddr == TOP_OFF) top_r <= pwdata[15:0];
      if (wrDone && paddr == BOTTOM_OFF) bot_r <= pwdata[15:0];
      if (wrDone && paddr == LEVEL_OFF) lvl_r <= pwdata[15:0];
      if (wrDone && paddr == HYST_OFF) hys_r <= pwdata[15:0];
      quiet_r <= wrDone ? 2'h0 : quiet_r + {1'b0, quiet_r != 2'h3};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_ready_access:
    assert property (pready == (psel && penable)) else $error("bad pready");
  a_err_ready:
    assert property (pslverr |-> pready) else $error("lone pslverr");
  a_err_unmapped:
    assert property (pready && paddr[1:0] == 2'h0 |->
      pslverr == (paddr > INTSTAT_OFF)) else $error("bad pslverr");
  a_below_event:
    assert property (settled && mode == MODE_BELOW |->
      compEvent == $past(sel < lvl_r, 2)) else $error("below event");
  a_above_event:
    assert property (settled && mode == MODE_ABOVE |->
      compEvent == $past(sel > lvl_r, 2)) else $error("above event");
  a_rise_refs:
    assert property (settled && mode == MODE_HYST_RISE |-> dacUpper == lvl_r
      && dacLower == (lvl_r >= hys_r ? lvl_r - hys_r : 16'h0000))
      else $error("rise refs");
  a_fall_refs:
    assert property (settled && mode == MODE_HYST_FALL |-> dacLower == lvl_r
      && dacUpper == (upSum[16] ? 16'hFFFF : upSum[15:0]))
      else $error("fall refs");
  a_disabled_quiet:
    assert property (quiet_r == 2'h3 && !ctl_r[0] |-> !compEvent)
      else $error("event while off");
  a_win_refs:
    assert property (settled && (mode == MODE_WIN_ENTER
      || mode == MODE_WIN_LEAVE) |-> dacUpper == top_r
      && dacLower == bot_r) else $error("window refs");
  a_enter_event:
    assert property (settled && mode == MODE_WIN_ENTER |->
      compEvent == $past(sel >= bot_r && sel <= top_r, 2))
      else $error("enter event");
  a_route_copy:
    assert property (quiet_r == 2'h3 |->
      aiTrigger == (compEvent && ctl_r[6])
      && aoTrigger == (compEvent && ctl_r[7])
      && ctrTrigger == (compEvent && ctl_r[8])) else $error("bad route");
endmodule : analog_trigger_detect_chk

bind analog_trigger_detect analog_trigger_detect_chk chk (.clk_sys, .reset,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .chanSamples, .dacUpper, .dacLower, .compEvent, .aiTrigger, .aoTrigger,
  .ctrTrigger);

// file: verif/analog_trigger_detect_bench.sv
// self-checking bench of the analog trigger detector
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
$display("mismatch %s exp %h got %h", n, e, g); end end
module analog_trigger_detect_bench;
  import trig_pkg::*;
  typedef struct {mode_type m; logic [1:0] c; logic [15:0] a, b, s;
    logic e;} row_type;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, perr, compEvent, irq;
  logic aiTrigger, aoTrigger, ctrTrigger;
  logic [SAMPLE_W-1:0] dacUpper, dacLower;
  logic [SAMPLE_W-1:0] level = 16'h2000;
  logic [CH_W-1:0] chan = 2'h0;
  logic [NUM_CH*SAMPLE_W-1:0] chanSamples;
  int mismatches = 0;
  int checks = 0;
  row_type rows [8] = '{
    '{MODE_BELOW, 2'h0, 16'h1000, 16'h0, 16'h0FFF, 1'b1},
    '{MODE_BELOW, 2'h0, 16'h1000, 16'h0, 16'h1000, 1'b0},
    '{MODE_ABOVE, 2'h1, 16'h1000, 16'h0, 16'h1001, 1'b1},
    '{MODE_ABOVE, 2'h1, 16'h1000, 16'h0, 16'h1000, 1'b0},
    '{MODE_WIN_ENTER, 2'h2, 16'h2000, 16'h1000, 16'h1000, 1'b1},
    '{MODE_WIN_ENTER, 2'h2, 16'h2000, 16'h1000, 16'h0FFF, 1'b0},
    '{MODE_WIN_LEAVE, 2'h3, 16'h2000, 16'h1000, 16'h2001, 1'b1},
    '{MODE_WIN_LEAVE, 2'h3, 16'h2000, 16'h1000, 16'h2000, 1'b0}};
  logic [15:0] hs [5] = '{16'h1200, 16'h0E00, 16'h1001, 16'h0F80, 16'h0EFF};
  logic he [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  always #5 clk_sys = ~clk_sys;
  analog_trigger_detect uut (.clk_sys, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .chanSamples, .dacUpper,
    .dacLower, .compEvent, .aiTrigger, .aoTrigger, .ctrTrigger, .irq);
  afe_model afe (.chan, .level, .chanSamples);
  task automatic finish_test;
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 9);
    if (pready !== 1'b1) begin
      mismatches++;
      finish_test();
    end
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("rdata", e, rdat)
  endtask : rd
  task automatic setup(input mode_type m, input logic [1:0] c,
      input logic [15:0] a, b, h);
    chan <= c;
    apb(1'b1, LEVEL_OFF, {16'h0, a});
    apb(1'b1, HYST_OFF, {16'h0, h});
    apb(1'b1, TOP_OFF, {16'h0, a});
    apb(1'b1, BOTTOM_OFF, {16'h0, b});
    apb(1'b1, CTRL_OFF, {26'h0, c, m, 1'b1});
    @(posedge clk_sys);
  endtask : setup
  task automatic step(input logic [15:0] s, input logic e);
    level <= s;
    repeat (4) @(posedge clk_sys);
    `CHK("event", e, compEvent)
  endtask : step
  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    `CHK("irq", 1'b0, irq)
    rd(CTRL_OFF, CTRL_RST);
    rd(LEVEL_OFF, 32'h0);
    rd(INTMASK_OFF, 32'h0);
    rd(8'h20, 32'h0);
    `CHK("err", 1'b1, perr)
    apb(1'b1, CTRL_OFF, 32'hFFFFFFFE);
    rd(CTRL_OFF, 32'h1FE);
    foreach (rows[i]) begin
      setup(rows[i].m, rows[i].c, rows[i].a, rows[i].b, 16'h0);
      step(rows[i].s, rows[i].e);
    end
    setup(MODE_HYST_RISE, 2'h1, 16'h1000, 16'h0, 16'h0100);
    `CHK("upper", 16'h1000, dacUpper)
    `CHK("lower", 16'h0F00, dacLower)
    foreach (hs[i]) step(hs[i], he[i]);
    setup(MODE_HYST_FALL, 2'h1, 16'h1000, 16'h0, 16'h0100);
    `CHK("upper", 16'h1100, dacUpper)
    `CHK("lower", 16'h1000, dacLower)
    foreach (hs[i]) step(16'h2000 - hs[i], he[i]);
    setup(MODE_BELOW, 2'h2, 16'h1000, 16'h0, 16'h0);
    apb(1'b1, INTMASK_OFF, 32'h1);
    apb(1'b0, INTSTAT_OFF, 32'h0);
    step(16'h0500, 1'b1);
    repeat (2) @(posedge clk_sys);
    `CHK("irq", 1'b1, irq)
    rd(INTSTAT_OFF, 32'h1);
    @(posedge clk_sys);
    `CHK("irq", 1'b0, irq)
    step(16'h2000, 1'b0);
    `CHK("irq", 1'b0, irq)
    rd(INTSTAT_OFF, 32'h2);
    apb(1'b1, CTRL_OFF, {23'h0, 3'b101, 2'h2, MODE_BELOW, 1'b1});
    step(16'h0500, 1'b1);
    `CHK("ai", 1'b1, aiTrigger)
    `CHK("ao", 1'b0, aoTrigger)
    `CHK("ctr", 1'b1, ctrTrigger)
    apb(1'b1, CTRL_OFF, {23'h0, 3'b010, 2'h2, MODE_BELOW, 1'b1});
    step(16'h0400, 1'b1);
    `CHK("ai", 1'b0, aiTrigger)
    `CHK("ao", 1'b1, aoTrigger)
    `CHK("ctr", 1'b0, ctrTrigger)
    rd(STATUS_OFF, 32'h1);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    `CHK("event", 1'b0, compEvent)
    `CHK("irq", 1'b0, irq)
    `CHK("upper", 16'h0000, dacUpper)
    rd(CTRL_OFF, CTRL_RST);
    rd(STATUS_OFF, 32'h0);
    finish_test();
  end
endmodule : analog_trigger_detect_bench
